// >>> verilog/lctjtc_pkg.sv
// package: register map, field layout and decode types of the per-channel config bank
package lctjtc_pkg;

  localparam int         NUM_CHANNELS       = 14;
  // address = {channel, offset}
  localparam int         ADDR_CHAN_MSB      = 7;
  localparam int         ADDR_CHAN_LSB      = 4;
  localparam logic [3:0] OFF_TERM_JITTER    = 4'h1;
  localparam logic [3:0] OFF_TEST_PATTERN   = 4'h2;
  localparam logic       SLOT_TERM          = 1'h0;
  localparam logic       SLOT_PATTERN       = 1'h1;

  localparam logic [7:0] RESET_TERM_JITTER  = 8'h00;
  localparam logic [7:0] RESET_TEST_PATTERN = 8'h00;
  localparam logic [7:0] UNMAPPED_READ      = 8'h00;
  localparam logic [1:0] STROBE_IDLE        = 2'h3;
  // low nibble of the pattern register belongs to the power and loopback logic
  localparam logic [7:0] MASK_TERM_JITTER   = 8'hFF;
  localparam logic [7:0] MASK_TEST_PATTERN  = 8'hF0;

  // termination / jitter register fields
  localparam int         BIT_RX_TERM        = 7;
  localparam int         BIT_TX_TERM        = 6;
  localparam int         BIT_IMP_MSB        = 5;
  localparam int         BIT_IMP_LSB        = 4;
  localparam int         BIT_RX_JA          = 3;
  localparam int         BIT_TX_JA          = 2;
  localparam int         BIT_JA_BW          = 1;
  localparam int         BIT_FIFO_DEPTH     = 0;
  // test pattern register fields
  localparam int         BIT_PAT_INVERT     = 7;
  localparam int         BIT_PAT_MSB        = 6;
  localparam int         BIT_PAT_LSB        = 4;

  localparam logic [6:0] FIFO_DEPTH_SHALLOW   = 7'h20;
  localparam logic [6:0] FIFO_DEPTH_DEEP      = 7'h40;
  localparam logic [6:0] FIFO_LATENCY_SHALLOW = FIFO_DEPTH_SHALLOW >> 1;
  localparam logic [6:0] FIFO_LATENCY_DEEP    = FIFO_DEPTH_DEEP >> 1;

  // one-hot impedance select, bit n set for field code n
  typedef enum logic [3:0] {
    IMP_100_OHM = 4'h1,
    IMP_110_OHM = 4'h2,
    IMP_75_OHM  = 4'h4,
    IMP_120_OHM = 4'h8
  } lctjtc_imp_t;

  typedef enum logic [1:0] {
    BW_3_HZ   = 2'h0,
    BW_10_HZ  = 2'h1,
    BW_1P5_HZ = 2'h2
  } lctjtc_bw_t;

  // codes match the field, with every 0XX folded onto none
  typedef enum logic [2:0] {
    PAT_NONE                   = 3'h0,
    PAT_QRSS                   = 3'h4,
    PAT_ALL_ONES_PATTERN       = 3'h5,
    PAT_LOOP_UP_CODE_PATTERN   = 3'h6,
    PAT_LOOP_DOWN_CODE_PATTERN = 3'h7
  } lctjtc_pat_t;

endpackage : lctjtc_pkg

// >>> verilog/lctjtc_chan_decode.sv
// module: per-channel decode of the two config bytes into registered line controls
`timescale 1ns/100ps
module lctjtc_chan_decode (
  input  logic                     clk_sys,                 // system clock
  input  logic                     rst,                     // sync reset, active high
  input  logic [7:0]               cfg_term,                // termination / jitter byte
  input  logic [7:0]               cfg_pattern,             // test pattern byte
  input  logic                     e1_mode,                 // 1 = E1, 0 = T1/J1
  output logic                     rx_termination_select,   // 1 = rx internal termination
  output logic                     tx_termination_select,   // 1 = tx internal termination
  output lctjtc_pkg::lctjtc_imp_t  rx_impedance_onehot,     // selected line impedance
  output logic                     rx_jitter_atten_enable,  // rx attenuator on
  output logic                     tx_jitter_atten_enable,  // tx attenuator on
  output lctjtc_pkg::lctjtc_bw_t   jitter_bandwidth,        // attenuator corner
  output logic [6:0]               atten_fifo_depth,        // fifo depth in bits
  output logic [6:0]               atten_fifo_latency,      // fifo delay in bit periods
  output lctjtc_pkg::lctjtc_pat_t  tx_pattern,              // diagnostic pattern
  output logic                     test_pattern_invert      // qrss sent inverted
);

  typedef struct packed {
    logic                    rx_term;
    logic                    tx_term;
    lctjtc_pkg::lctjtc_imp_t imp;
    logic                    rx_ja;
    logic                    tx_ja;
    lctjtc_pkg::lctjtc_bw_t  bw;
    logic [6:0]              depth;
    logic [6:0]              latency;
    lctjtc_pkg::lctjtc_pat_t pat;
    logic                    pat_inv;
  } lctjtc_dec_state_t;

  // reset image is the decode of all-zero bytes in T1 mode
  localparam lctjtc_dec_state_t DEC_RESET = '{
    rx_term: 1'h0, tx_term: 1'h0, imp: lctjtc_pkg::IMP_100_OHM,
    rx_ja: 1'h0, tx_ja: 1'h0, bw: lctjtc_pkg::BW_3_HZ,
    depth: lctjtc_pkg::FIFO_DEPTH_SHALLOW, latency: lctjtc_pkg::FIFO_LATENCY_SHALLOW,
    pat: lctjtc_pkg::PAT_NONE, pat_inv: 1'h0};

  lctjtc_dec_state_t q;
  lctjtc_dec_state_t next_q;

  always_comb begin
    next_q         = q;
    next_q.rx_term = cfg_term[lctjtc_pkg::BIT_RX_TERM];
    next_q.tx_term = cfg_term[lctjtc_pkg::BIT_TX_TERM];
    next_q.imp     = lctjtc_pkg::lctjtc_imp_t'(4'h1 << cfg_term[lctjtc_pkg::BIT_IMP_MSB:
                                                            lctjtc_pkg::BIT_IMP_LSB]);
    next_q.rx_ja   = cfg_term[lctjtc_pkg::BIT_RX_JA];
    next_q.tx_ja   = cfg_term[lctjtc_pkg::BIT_TX_JA];
    if (!e1_mode) begin
      next_q.bw = lctjtc_pkg::BW_3_HZ;
    end else if (cfg_term[lctjtc_pkg::BIT_JA_BW]) begin
      next_q.bw = lctjtc_pkg::BW_1P5_HZ;
    end else begin
      next_q.bw = lctjtc_pkg::BW_10_HZ;
    end
    if (cfg_term[lctjtc_pkg::BIT_FIFO_DEPTH]) begin
      next_q.depth   = lctjtc_pkg::FIFO_DEPTH_DEEP;
      next_q.latency = lctjtc_pkg::FIFO_LATENCY_DEEP;
    end else begin
      next_q.depth   = lctjtc_pkg::FIFO_DEPTH_SHALLOW;
      next_q.latency = lctjtc_pkg::FIFO_LATENCY_SHALLOW;
    end
    if (cfg_pattern[lctjtc_pkg::BIT_PAT_MSB]) begin
      next_q.pat = lctjtc_pkg::lctjtc_pat_t'(cfg_pattern[lctjtc_pkg::BIT_PAT_MSB:
                                                         lctjtc_pkg::BIT_PAT_LSB]);
    end else begin
      next_q.pat = lctjtc_pkg::PAT_NONE;
    end
    // inversion only means something for the pseudo-random pattern
    next_q.pat_inv = cfg_pattern[lctjtc_pkg::BIT_PAT_INVERT] &&
                     (next_q.pat == lctjtc_pkg::PAT_QRSS);
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q <= DEC_RESET;
    end else begin
      q <= next_q;
    end
  end

  assign rx_termination_select  = q.rx_term;
  assign tx_termination_select  = q.tx_term;
  assign rx_impedance_onehot    = q.imp;
  assign rx_jitter_atten_enable = q.rx_ja;
  assign tx_jitter_atten_enable = q.tx_ja;
  assign jitter_bandwidth       = q.bw;
  assign atten_fifo_depth       = q.depth;
  assign atten_fifo_latency     = q.latency;
  assign tx_pattern             = q.pat;
  assign test_pattern_invert    = q.pat_inv;

  ////////////////////////////////////////////////////////////////////////////////
  chk_bw_t1_fixed: assert property (
    @(posedge clk_sys) disable iff (rst)
    !e1_mode |=> jitter_bandwidth == lctjtc_pkg::BW_3_HZ)
    else $error("t1 channel left the 3 Hz bandwidth");

  chk_bw_e1_select: assert property (
    @(posedge clk_sys) disable iff (rst)
    e1_mode |=> jitter_bandwidth == ($past(cfg_term[lctjtc_pkg::BIT_JA_BW]) ?
                                     lctjtc_pkg::BW_1P5_HZ : lctjtc_pkg::BW_10_HZ))
    else $error("e1 bandwidth does not follow the bandwidth bit");

  chk_fifo_depth_pair: assert property (
    @(posedge clk_sys) disable iff (rst)
    (cfg_term[lctjtc_pkg::BIT_FIFO_DEPTH] ##1 cfg_term[lctjtc_pkg::BIT_FIFO_DEPTH])
    |-> atten_fifo_depth == lctjtc_pkg::FIFO_DEPTH_DEEP)
    else $error("fifo depth not 64 while the deep bit is held");

  chk_latency_half: assert property (
    @(posedge clk_sys) disable iff (rst)
    atten_fifo_latency == (atten_fifo_depth >> 1))
    else $error("fifo latency is not half the depth");

endmodule : lctjtc_chan_decode

// >>> verilog/lctjtc_cfg_bank.sv
// module: microprocessor-port register bank holding termination, jitter and test pattern config
`timescale 1ns/100ps
module lctjtc_cfg_bank #(
  parameter int N_CHAN = lctjtc_pkg::NUM_CHANNELS  // channels in the bank
) (
  input  logic                                clk_sys,                 // system clock
  input  logic                                rst,                     // sync reset, high
  input  logic                                up_cs_n,                 // chip select pin
  input  logic                                up_wr_n,                 // write strobe pin
  input  logic                                up_rd_n,                 // read strobe pin
  input  logic [7:0]                          up_addr,                 // address pins
  input  logic [7:0]                          up_data_in,              // data bus, inbound
  output logic [7:0]                          up_data_out,             // data bus, outbound
  output logic                                up_data_oe,              // data bus driven
  input  logic [N_CHAN-1:0]                   e1_mode,                 // per channel E1
  output logic [N_CHAN-1:0]                   rx_termination_select,   // rx internal term
  output logic [N_CHAN-1:0]                   tx_termination_select,   // tx internal term
  output lctjtc_pkg::lctjtc_imp_t [N_CHAN-1:0] rx_impedance_onehot,    // line impedance
  output logic [N_CHAN-1:0]                   rx_jitter_atten_enable,  // rx attenuator on
  output logic [N_CHAN-1:0]                   tx_jitter_atten_enable,  // tx attenuator on
  output lctjtc_pkg::lctjtc_bw_t [N_CHAN-1:0] jitter_bandwidth,        // attenuator corner
  output logic [N_CHAN-1:0][6:0]              atten_fifo_depth,        // fifo depth, bits
  output logic [N_CHAN-1:0][6:0]              atten_fifo_latency,      // fifo delay, bits
  output lctjtc_pkg::lctjtc_pat_t [N_CHAN-1:0] tx_pattern,             // test pattern
  output logic [N_CHAN-1:0]                   test_pattern_invert      // qrss inverted
);

  typedef struct packed {
    logic [1:0]                  cs_n_s;   // [0] first stage, [1] second stage
    logic [1:0]                  wr_n_s;
    logic [1:0]                  rd_n_s;
    logic [1:0][7:0]             addr_s;
    logic [1:0][7:0]             wdata_s;
    logic                        wr_n_d;   // second stage delayed, for the edge
    logic [N_CHAN-1:0][1:0][7:0] regs;     // per channel {pattern, term}
    logic [7:0]                  rdata;
    logic                        rd_oe;
  } lctjtc_bus_state_t;

  lctjtc_bus_state_t q;
  lctjtc_bus_state_t next_q;
  lctjtc_bus_state_t bus_reset;

  logic [3:0]                  chan;
  logic [1:0]                  sel;
  logic                        take;
  logic                        rd_active;
  logic [7:0]                  rd_value;
  logic [N_CHAN-1:0][1:0][7:0] wmask;

  ////////////////////////////////////////////////////////////////////////////////
  // {pattern hit, term hit}; unmapped channels and offsets give zero
  function automatic logic [1:0] reg_select(input logic [7:0] addr);
    logic [3:0] ch;
    logic [3:0] off;
    ch  = addr[lctjtc_pkg::ADDR_CHAN_MSB:lctjtc_pkg::ADDR_CHAN_LSB];
    off = addr[lctjtc_pkg::ADDR_CHAN_LSB-1:0];
    reg_select = 2'h0;
    if (int'(ch) < N_CHAN) begin
      reg_select[lctjtc_pkg::SLOT_TERM]    = (off == lctjtc_pkg::OFF_TERM_JITTER);
      reg_select[lctjtc_pkg::SLOT_PATTERN] = (off == lctjtc_pkg::OFF_TEST_PATTERN);
    end
  endfunction : reg_select

  function automatic logic [7:0] reg_mask(input logic [7:0] addr);
    logic [1:0] s;
    s = reg_select(addr);
    case (s)
      2'h1:    reg_mask = lctjtc_pkg::MASK_TERM_JITTER;
      2'h2:    reg_mask = lctjtc_pkg::MASK_TEST_PATTERN;
      default: reg_mask = 8'h00;
    endcase
  endfunction : reg_mask

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    bus_reset        = '0;
    bus_reset.cs_n_s = lctjtc_pkg::STROBE_IDLE;
    bus_reset.wr_n_s = lctjtc_pkg::STROBE_IDLE;
    bus_reset.rd_n_s = lctjtc_pkg::STROBE_IDLE;
    bus_reset.wr_n_d = 1'h1;
    for (int c = 0; c < N_CHAN; c++) begin
      bus_reset.regs[c][lctjtc_pkg::SLOT_TERM]    = lctjtc_pkg::RESET_TERM_JITTER;
      bus_reset.regs[c][lctjtc_pkg::SLOT_PATTERN] = lctjtc_pkg::RESET_TEST_PATTERN;
    end
    bus_reset.rdata  = lctjtc_pkg::UNMAPPED_READ;
  end

  // strobes are taken only after both synchroniser stages
  assign chan      = q.addr_s[1][lctjtc_pkg::ADDR_CHAN_MSB:lctjtc_pkg::ADDR_CHAN_LSB];
  assign sel       = reg_select(q.addr_s[1]);
  assign take      = !q.cs_n_s[1] && !q.wr_n_s[1] && q.wr_n_d;
  assign rd_active = !q.cs_n_s[1] && !q.rd_n_s[1];

  always_comb begin
    case (sel)
      2'h1:    rd_value = q.regs[chan][lctjtc_pkg::SLOT_TERM];
      2'h2:    rd_value = q.regs[chan][lctjtc_pkg::SLOT_PATTERN];
      default: rd_value = lctjtc_pkg::UNMAPPED_READ;
    endcase
  end

  always_comb begin
    next_q         = q;
    next_q.cs_n_s  = {q.cs_n_s[0], up_cs_n};
    next_q.wr_n_s  = {q.wr_n_s[0], up_wr_n};
    next_q.rd_n_s  = {q.rd_n_s[0], up_rd_n};
    next_q.addr_s  = {q.addr_s[0], up_addr};
    next_q.wdata_s = {q.wdata_s[0], up_data_in};
    next_q.wr_n_d  = q.wr_n_s[1];
    // one write per falling edge of the strobe, so a long pulse writes once
    if (take && sel[lctjtc_pkg::SLOT_TERM]) begin
      next_q.regs[chan][lctjtc_pkg::SLOT_TERM] =
        q.wdata_s[1] & lctjtc_pkg::MASK_TERM_JITTER;
    end
    if (take && sel[lctjtc_pkg::SLOT_PATTERN]) begin
      next_q.regs[chan][lctjtc_pkg::SLOT_PATTERN] =
        q.wdata_s[1] & lctjtc_pkg::MASK_TEST_PATTERN;
    end
    next_q.rd_oe = rd_active;
    next_q.rdata = rd_active ? rd_value : lctjtc_pkg::UNMAPPED_READ;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q <= bus_reset;
    end else begin
      q <= next_q;
    end
  end

  assign up_data_out = q.rdata;
  assign up_data_oe  = q.rd_oe;

  ////////////////////////////////////////////////////////////////////////////////
  for (genvar ch = 0; ch < N_CHAN; ch++) begin : g_chan
    lctjtc_chan_decode u_decode (
      .clk_sys                (clk_sys),
      .rst                    (rst),
      .cfg_term               (q.regs[ch][lctjtc_pkg::SLOT_TERM]),
      .cfg_pattern            (q.regs[ch][lctjtc_pkg::SLOT_PATTERN]),
      .e1_mode                (e1_mode[ch]),
      .rx_termination_select  (rx_termination_select[ch]),
      .tx_termination_select  (tx_termination_select[ch]),
      .rx_impedance_onehot    (rx_impedance_onehot[ch]),
      .rx_jitter_atten_enable (rx_jitter_atten_enable[ch]),
      .tx_jitter_atten_enable (tx_jitter_atten_enable[ch]),
      .jitter_bandwidth       (jitter_bandwidth[ch]),
      .atten_fifo_depth       (atten_fifo_depth[ch]),
      .atten_fifo_latency     (atten_fifo_latency[ch]),
      .tx_pattern             (tx_pattern[ch]),
      .test_pattern_invert    (test_pattern_invert[ch])
    );
  end

  ////////////////////////////////////////////////////////////////////////////////
  // assertion helpers: bits a write is allowed to touch
  always_comb begin
    wmask = '0;
    if (take && sel[lctjtc_pkg::SLOT_TERM]) begin
      wmask[chan][lctjtc_pkg::SLOT_TERM] = 8'hFF;
    end
    if (take && sel[lctjtc_pkg::SLOT_PATTERN]) begin
      wmask[chan][lctjtc_pkg::SLOT_PATTERN] = 8'hFF;
    end
  end

  sequence seq_wr_falling;
    (!q.cs_n_s[1] && q.wr_n_s[1]) ##1 (!q.cs_n_s[1] && !q.wr_n_s[1]);
  endsequence

  sequence seq_term_write;
    seq_wr_falling ##0 sel[lctjtc_pkg::SLOT_TERM];
  endsequence

  sequence seq_pattern_write;
    seq_wr_falling ##0 sel[lctjtc_pkg::SLOT_PATTERN];
  endsequence

  property p_term_bit(int b, logic [N_CHAN-1:0] outv);
    logic [3:0] c;
    logic       v;
    @(posedge clk_sys) disable iff (rst)
    (seq_term_write, c = chan, v = q.wdata_s[1][b]) |-> ##2 outv[c] == v;
  endproperty

  chk_rx_term_follow: assert property (
    p_term_bit(lctjtc_pkg::BIT_RX_TERM, rx_termination_select))
    else $error("rx termination does not follow its written bit");

  chk_tx_term_follow: assert property (
    p_term_bit(lctjtc_pkg::BIT_TX_TERM, tx_termination_select))
    else $error("tx termination does not follow its written bit");

  chk_rx_ja_follow: assert property (
    p_term_bit(lctjtc_pkg::BIT_RX_JA, rx_jitter_atten_enable))
    else $error("rx attenuator enable does not follow its written bit");

  chk_tx_ja_follow: assert property (
    p_term_bit(lctjtc_pkg::BIT_TX_JA, tx_jitter_atten_enable))
    else $error("tx attenuator enable does not follow its written bit");

  property p_impedance;
    logic [3:0] c;
    logic [1:0] v;
    @(posedge clk_sys) disable iff (rst)
    (seq_term_write, c = chan,
     v = q.wdata_s[1][lctjtc_pkg::BIT_IMP_MSB:lctjtc_pkg::BIT_IMP_LSB])
    |-> ##2 rx_impedance_onehot[c] == (4'h1 << v);
  endproperty

  chk_impedance_code: assert property (p_impedance)
    else $error("impedance select does not match the written code");

  property p_pattern;
    logic [3:0] c;
    logic [7:0] v;
    @(posedge clk_sys) disable iff (rst)
    (seq_pattern_write, c = chan, v = q.wdata_s[1])
    |-> ##2 tx_pattern[c] == (v[lctjtc_pkg::BIT_PAT_MSB] ?
                              v[lctjtc_pkg::BIT_PAT_MSB:lctjtc_pkg::BIT_PAT_LSB] : 3'h0);
  endproperty

  chk_pattern_select: assert property (p_pattern)
    else $error("test pattern does not match the written field");

  property p_invert;
    logic [3:0] c;
    logic [7:0] v;
    @(posedge clk_sys) disable iff (rst)
    (seq_pattern_write, c = chan, v = q.wdata_s[1])
    |-> ##2 test_pattern_invert[c] == (v[lctjtc_pkg::BIT_PAT_INVERT] &&
            v[lctjtc_pkg::BIT_PAT_MSB:lctjtc_pkg::BIT_PAT_LSB] == lctjtc_pkg::PAT_QRSS);
  endproperty

  chk_pattern_invert: assert property (p_invert)
    else $error("qrss inversion does not follow the written bit");

  property p_fifo_depth;
    logic [3:0] c;
    logic       v;
    @(posedge clk_sys) disable iff (rst)
    (seq_term_write, c = chan, v = q.wdata_s[1][lctjtc_pkg::BIT_FIFO_DEPTH])
    |-> ##2 atten_fifo_depth[c] ==
            (v ? lctjtc_pkg::FIFO_DEPTH_DEEP : lctjtc_pkg::FIFO_DEPTH_SHALLOW);
  endproperty

  chk_fifo_depth_write: assert property (p_fifo_depth)
    else $error("fifo depth does not follow the written bit");

  property p_fifo_delay;
    logic [3:0] c;
    logic       v;
    @(posedge clk_sys) disable iff (rst)
    (seq_term_write, c = chan, v = q.wdata_s[1][lctjtc_pkg::BIT_FIFO_DEPTH])
    |-> ##2 atten_fifo_latency[c] ==
            (v ? lctjtc_pkg::FIFO_LATENCY_DEEP : lctjtc_pkg::FIFO_LATENCY_SHALLOW);
  endproperty

  chk_fifo_delay_write: assert property (p_fifo_delay)
    else $error("fifo latency does not follow the written bit");

  chk_chan_isolation: assert property (
    @(posedge clk_sys) disable iff (rst)
    1'h1 |=> ((q.regs ^ $past(q.regs)) & ~$past(wmask)) == '0)
    else $error("a write changed a register it did not address");

  // read-back split in two halves, since wr and rd strobes never overlap
  property p_write_lands;
    logic [3:0] c;
    logic       s;
    logic [7:0] d;
    @(posedge clk_sys) disable iff (rst)
    (seq_wr_falling ##0 (sel != 2'h0), c = chan, s = sel[lctjtc_pkg::SLOT_PATTERN],
     d = q.wdata_s[1] & reg_mask(q.addr_s[1]))
    |=> q.regs[c][s] == d;
  endproperty

  chk_write_lands: assert property (p_write_lands)
    else $error("written value did not land in the addressed register");

  property p_read_returns;
    logic [7:0] v;
    @(posedge clk_sys) disable iff (rst)
    (rd_active && sel != 2'h0, v = q.regs[chan][sel[lctjtc_pkg::SLOT_PATTERN]])
    |=> up_data_oe && up_data_out == v;
  endproperty

  chk_read_returns: assert property (p_read_returns)
    else $error("read data differs from the stored register");

  chk_reset_clear: assert property (
    @(posedge clk_sys)
    rst |=> q.regs == '0 && !up_data_oe)
    else $error("registers not cleared by reset");

  chk_unmapped_zero: assert property (
    @(posedge clk_sys) disable iff (rst)
    (rd_active && sel == 2'h0) |=> up_data_oe && up_data_out == lctjtc_pkg::UNMAPPED_READ)
    else $error("unmapped read returned nonzero data");

  chk_bus_released: assert property (
    @(posedge clk_sys) disable iff (rst)
    !rd_active |=> !up_data_oe && up_data_out == lctjtc_pkg::UNMAPPED_READ)
    else $error("data bus driven with no read active");

  // low nibble of the pattern slot belongs elsewhere and must never be stored
  for (genvar ch = 0; ch < N_CHAN; ch++) begin : g_low_nibble
    chk_pattern_low_zero: assert property (
      @(posedge clk_sys) disable iff (rst)
      q.regs[ch][lctjtc_pkg::SLOT_PATTERN][3:0] == 4'h0)
      else $error("pattern register low nibble holds a stored bit");
  end

endmodule : lctjtc_cfg_bank

// >>> verif/lctjtc_cfg_bank_bench.sv
// testbench: per-channel config bank, register writes, read-back and decoded line controls
`timescale 1ns/100ps
module lctjtc_cfg_bank_bench;
  localparam int NC = lctjtc_pkg::NUM_CHANNELS;
  logic                             clk_sys     = 1'b0;
  logic                             rst         = 1'b1;
  logic                             up_cs_n     = 1'b1;
  logic                             up_wr_n     = 1'b1;
  logic                             up_rd_n     = 1'b1;
  logic [7:0]                       up_addr     = 8'h00;
  logic [7:0]                       up_data_in  = 8'h00;
  logic [NC-1:0]                    e1_mode     = '0;
  logic [7:0]                       up_data_out;
  logic                             up_data_oe;
  logic [NC-1:0]                    rx_term, tx_term, rx_ja, tx_ja, pat_inv;
  lctjtc_pkg::lctjtc_imp_t [NC-1:0] imp;
  lctjtc_pkg::lctjtc_bw_t [NC-1:0]  bw;
  logic [NC-1:0][6:0]               depth, lat;
  lctjtc_pkg::lctjtc_pat_t [NC-1:0] pat;
  logic [7:0]                       term_m [NC];
  logic [7:0]                       pat_m [NC];
  logic [7:0]                       a;
  int error_cnt = 0, check_count = 0, cycles = 0, seed = 40725;

  lctjtc_cfg_bank #(.N_CHAN(NC)) dut (
    .clk_sys(clk_sys), .rst(rst), .up_cs_n(up_cs_n), .up_wr_n(up_wr_n), .up_rd_n(up_rd_n),
    .up_addr(up_addr), .up_data_in(up_data_in), .up_data_out(up_data_out),
    .up_data_oe(up_data_oe), .e1_mode(e1_mode), .rx_termination_select(rx_term),
    .tx_termination_select(tx_term), .rx_impedance_onehot(imp),
    .rx_jitter_atten_enable(rx_ja), .tx_jitter_atten_enable(tx_ja),
    .jitter_bandwidth(bw), .atten_fifo_depth(depth), .atten_fifo_latency(lat),
    .tx_pattern(pat), .test_pattern_invert(pat_inv));

  always #5 clk_sys = ~clk_sys;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : test_done

  // ceiling well above the ~2200 cycles the sequence needs
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      test_done();
    end
  end

  task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : cmp

  function automatic logic [7:0] exp_rd(input logic [7:0] ad);
    if (ad[7:4] >= NC) return 8'h00;
    if (ad[3:0] == 4'h1) return term_m[ad[7:4]];
    if (ad[3:0] == 4'h2) return pat_m[ad[7:4]];
    return 8'h00;
  endfunction : exp_rd

  // address and data held from before wr falls until well after the take
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(negedge clk_sys);
    up_addr = ad;
    up_data_in = d;
    up_cs_n = 1'b0;
    @(negedge clk_sys);
    up_wr_n = 1'b0;
    repeat (4) @(negedge clk_sys);
    up_wr_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    up_cs_n = 1'b1;
    if (ad[7:4] < NC && ad[3:0] == 4'h1) term_m[ad[7:4]] = d;
    if (ad[7:4] < NC && ad[3:0] == 4'h2) pat_m[ad[7:4]] = d & 8'hF0;
  endtask : wr

  task automatic rd(input logic [7:0] ad);
    @(negedge clk_sys);
    up_addr = ad;
    up_cs_n = 1'b0;
    up_rd_n = 1'b0;
    repeat (5) @(negedge clk_sys);
    cmp("read data", exp_rd(ad), up_data_out);
    cmp("read enable", 8'h01, {7'h0, up_data_oe});
    up_rd_n = 1'b1;
    up_cs_n = 1'b1;
    repeat (5) @(negedge clk_sys);
    cmp("released enable", 8'h00, {7'h0, up_data_oe});
  endtask : rd

  task automatic chk_chan(input int c);
    logic [7:0] t;
    logic [7:0] p;
    t = term_m[c];
    p = pat_m[c];
    cmp("rx term", {7'h0, t[7]}, {7'h0, rx_term[c]});
    cmp("tx term", {7'h0, t[6]}, {7'h0, tx_term[c]});
    cmp("impedance", {4'h0, 4'h1 << t[5:4]}, {4'h0, imp[c]});
    cmp("ja enables", {6'h0, t[3:2]}, {6'h0, rx_ja[c], tx_ja[c]});
    cmp("bandwidth", {6'h0, e1_mode[c] ? (t[1] ? 2'h2 : 2'h1) : 2'h0}, {6'h0, bw[c]});
    cmp("depth", {1'b0, t[0] ? 7'h40 : 7'h20}, {1'b0, depth[c]});
    cmp("latency", {1'b0, t[0] ? 7'h20 : 7'h10}, {1'b0, lat[c]});
    cmp("pattern", {5'h0, p[6] ? p[6:4] : 3'h0}, {5'h0, pat[c]});
    cmp("invert", {7'h0, p[7] && p[6:4] == 3'h4}, {7'h0, pat_inv[c]});
  endtask : chk_chan

  task automatic reset_all;
    rst = 1'b1;
    foreach (term_m[c]) term_m[c] = 8'h00;
    foreach (pat_m[c]) pat_m[c] = 8'h00;
    repeat (4) @(negedge clk_sys);
    rst = 1'b0;
    repeat (3) @(negedge clk_sys);
    for (int c = 0; c < NC; c++) chk_chan(c);
  endtask : reset_all

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    e1_mode = NC'($random(seed));
    reset_all();
    // every pattern code, with and without inversion
    for (int k = 0; k < 16; k++) begin
      wr(8'h52, 8'(k << 4));
      chk_chan(5);
    end
    // unmapped channels and offsets appear among the random addresses
    for (int i = 0; i < 80; i++) begin
      e1_mode = NC'($random(seed));
      a = {4'($random(seed)), 4'(i % 4)};
      wr(a, 8'($random(seed)));
      rd(a);
      if (a[7:4] < NC) chk_chan(int'(a[7:4]));
    end
    for (int c = 0; c < NC; c++) begin
      rd({4'(c), 4'h1});
      rd({4'(c), 4'h2});
    end
    reset_all();
    rd(8'hD1);
    test_done();
  end
endmodule : lctjtc_cfg_bank_bench
